// ### src/bwio_pkg.sv
// package: register map, field positions, reset values and timing figures
package bwio_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h0C;
  localparam logic [7:0] OFF_IRQ_EN = 8'h10;
  // control register field positions
  localparam int CTRL_WAKE_OUT_EN = 0;
  localparam int CTRL_BOOT_EVENT_DISABLE = 1;
  localparam int CTRL_LEVEL_SEL = 2;
  localparam int CTRL_WAKE_ROUTE2 = 3;
  localparam int CTRL_BOOT_ROUTE2 = 4;
  localparam int CTRL_W = 5;
  // event bits, shared by status, clear and enable registers
  localparam int EV_BOOT = 0;
  localparam int EV_WAKE_IN = 1;
  localparam int EV_WAKE_OUT = 2;
  localparam int EV_W = 3;
  // status register field positions
  localparam int ST_PWR_LSB = 0;
  localparam int ST_STRAP = 2;
  localparam int ST_SHORT = 3;
  localparam int ST_LONG = 4;
  localparam int ST_PIN1 = 5;
  localparam int ST_PIN2 = 6;
  // reset values
  localparam logic [CTRL_W-1:0] RST_CTRL = 5'h00;
  localparam logic [EV_W-1:0] RST_EV = 3'h0;
  // power state code for wake
  localparam logic [1:0] PWR_WAKE = 2'h1;
  // time unit conversions for the pulse lengths
  localparam int NS_PER_US = 1000;
  localparam int NS_PER_MS = 1000000;
  // clock period and pulse counter width
  localparam int CLK_PERIOD_NS = 20;
  localparam int CNT_W = 24;
  typedef logic [CNT_W-1:0] bwio_cnt_t;
endpackage : bwio_pkg

// ### src/bwio_pulse_timer.sv
// pulse timer: holds busy for a programmed number of clock cycles
`timescale 1ns/1ps
module bwio_pulse_timer (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic start,
  input wire bwio_pkg::bwio_cnt_t len,
  output logic busy
);
  import bwio_pkg::*;

  // all timer state
  typedef struct packed {
    logic busy;
    bwio_cnt_t cnt;
  } bwio_tmr_s;

  bwio_tmr_s s; // registered state
  bwio_tmr_s next_s; // next state

  // count down from len - 1 to zero; a start while busy restarts the pulse
  always_comb begin
    next_s = s;
    if (start) begin
      next_s.busy = 1'b1;
      next_s.cnt = len - bwio_cnt_t'(1);
    end else if (s.busy) begin
      if (s.cnt == '0) begin
        next_s.busy = 1'b0;
      end else begin
        next_s.cnt = s.cnt - bwio_cnt_t'(1);
      end
    end
  end

  // state register
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy = s.busy;
endmodule : bwio_pulse_timer

// ### src/bwio_irq_out.sv
// boot and wake interrupt output logic with apb register slave
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module bwio_irq_out #(
  parameter int BOOT_SHORT_US = 10,
  parameter int BOOT_LONG_MS = 1
) (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [1:0] POWER_STATE,
  input wire logic BOOT_STRAP_SELECT,
  input wire logic BOOT_START,
  input wire logic BOOT_DONE_EVENT,
  input wire logic SOFT_RESET,
  input wire logic DEEP_POWER_OFF,
  output logic FIRST_IRQ_PIN,
  output logic SECOND_IRQ_BOOT_PIN,
  output logic IRQ
);
  import bwio_pkg::*;

  // pulse lengths in cycles, never below one
  // a zero time still gives a one-cycle pulse, so the event is never lost
  localparam int SHORT_NS = BOOT_SHORT_US * NS_PER_US;
  localparam int LONG_NS = BOOT_LONG_MS * NS_PER_MS;
  localparam int SHORT_RAW = SHORT_NS / CLK_PERIOD_NS;
  localparam int LONG_RAW = LONG_NS / CLK_PERIOD_NS;
  localparam bwio_cnt_t SHORT_CYC = bwio_cnt_t'((SHORT_RAW < 1) ? 1 : SHORT_RAW);
  localparam bwio_cnt_t LONG_CYC = bwio_cnt_t'((LONG_RAW < 1) ? 1 : LONG_RAW);

  // all block state
  typedef struct packed {
    logic wake_out_en; // wake state output enable
    logic boot_event_disable; // boot event suppressed while strap low
    logic irq_level_select; // 1: active high, 0: active low
    logic wake_state_route_second; // wake output on second pin while strap low
    logic boot_route_second; // boot event on second pin
    logic [EV_W-1:0] irq_stat; // sticky event bits
    logic [EV_W-1:0] irq_en; // event enables
    logic strap_taken; // strap sampled after reset release
    logic boot_strap_select; // latched strap level
    logic wake_prev; // wake state one cycle ago
    logic pready; // apb ready
    logic pslverr; // apb error
    logic [31:0] prdata; // apb read data
    logic irq; // interrupt level
    logic pin1; // first interrupt pin level
    logic pin2; // second interrupt pin level
  } bwio_state_s;

  bwio_state_s s; // registered state
  bwio_state_s next_s; // next state

  logic short_busy; // short boot pulse running
  logic long_busy; // long boot pulse running
  logic short_start; // launch short pulse
  logic long_start; // launch long pulse
  logic wake_now; // device in wake state
  logic wake_on; // wake indication active
  logic apb_access; // access phase, answer not yet given
  logic wr_commit; // write completes this edge
  logic [EV_W-1:0] ev; // events seen this cycle

  // true when the address is one of the mapped words
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_IRQ_STAT) ||
              (a == OFF_IRQ_CLR) || (a == OFF_IRQ_EN);
  endfunction : reg_hit

  // short pulse timer
  bwio_pulse_timer u_short (
    .CLK_SYS(CLK_SYS),
    .RST_B(RST_B),
    .start(short_start),
    .len(SHORT_CYC),
    .busy(short_busy)
  );

  // long pulse timer
  bwio_pulse_timer u_long (
    .CLK_SYS(CLK_SYS),
    .RST_B(RST_B),
    .start(long_start),
    .len(LONG_CYC),
    .busy(long_busy)
  );

  // event and handshake decode
  always_comb begin
    // strap low: short pulse only when not disabled
    short_start = BOOT_DONE_EVENT && s.strap_taken && !s.boot_strap_select &&
                  !s.boot_event_disable;
    // strap high: forced long pulse, disable ignored
    long_start = BOOT_START && s.strap_taken && s.boot_strap_select;
    wake_now = (POWER_STATE == PWR_WAKE);
    wake_on = s.wake_out_en && wake_now;
    apb_access = PSEL && PENABLE && !s.pready;
    wr_commit = PSEL && PENABLE && s.pready && PWRITE && !s.pslverr;
    ev = RST_EV;
    ev[EV_BOOT] = short_start || long_start;
    ev[EV_WAKE_IN] = wake_now && !s.wake_prev;
    ev[EV_WAKE_OUT] = !wake_now && s.wake_prev;
  end

  // next state: strap, bus, status, pins
  always_comb begin
    logic act1; // first pin asserted
    logic act2; // second pin asserted
    act1 = 1'b0;
    act2 = 1'b0;
    next_s = s;
    next_s.wake_prev = wake_now;
    // sample strap once, after reset release
    // a later change of the strap pin is ignored until the next power-up
    if (!s.strap_taken) begin
      next_s.strap_taken = 1'b1;
      next_s.boot_strap_select = BOOT_STRAP_SELECT;
    end
    // apb answer one cycle into the access phase
    next_s.pready = apb_access;
    if (apb_access) begin
      next_s.pslverr = !reg_hit(PADDR);
      next_s.prdata = '0;
      if (!PWRITE) begin
        unique case (PADDR)
          OFF_CTRL: begin
            next_s.prdata[CTRL_WAKE_OUT_EN] = s.wake_out_en;
            next_s.prdata[CTRL_BOOT_EVENT_DISABLE] = s.boot_event_disable;
            next_s.prdata[CTRL_LEVEL_SEL] = s.irq_level_select;
            next_s.prdata[CTRL_WAKE_ROUTE2] = s.wake_state_route_second;
            next_s.prdata[CTRL_BOOT_ROUTE2] = s.boot_route_second;
          end
          OFF_STATUS: begin
            next_s.prdata[ST_PWR_LSB +: 2] = POWER_STATE;
            next_s.prdata[ST_STRAP] = s.boot_strap_select;
            next_s.prdata[ST_SHORT] = short_busy;
            next_s.prdata[ST_LONG] = long_busy;
            next_s.prdata[ST_PIN1] = s.pin1;
            next_s.prdata[ST_PIN2] = s.pin2;
          end
          OFF_IRQ_STAT: begin
            next_s.prdata[EV_W-1:0] = s.irq_stat;
          end
          OFF_IRQ_EN: begin
            next_s.prdata[EV_W-1:0] = s.irq_en;
          end
          default: begin
            next_s.prdata = '0; // clear register and holes read zero
          end
        endcase
      end
    end else if (!(PSEL && PENABLE)) begin
      // error stays up with ready, dropped once the request goes away
      next_s.pslverr = 1'b0;
    end
    // register writes take effect at the completing edge
    if (wr_commit) begin
      unique case (PADDR)
        OFF_CTRL: begin
          next_s.wake_out_en = PWDATA[CTRL_WAKE_OUT_EN];
          next_s.boot_event_disable = PWDATA[CTRL_BOOT_EVENT_DISABLE];
          next_s.irq_level_select = PWDATA[CTRL_LEVEL_SEL];
          next_s.wake_state_route_second = PWDATA[CTRL_WAKE_ROUTE2];
          next_s.boot_route_second = PWDATA[CTRL_BOOT_ROUTE2];
        end
        OFF_IRQ_CLR: begin
          next_s.irq_stat = s.irq_stat & ~PWDATA[EV_W-1:0];
        end
        OFF_IRQ_EN: begin
          next_s.irq_en = PWDATA[EV_W-1:0];
        end
        default: begin
          next_s.irq_stat = next_s.irq_stat; // read-only words ignore writes
        end
      endcase
    end
    // soft reset keeps boot disable and boot routing
    // the boot routing bit sits three places above the disable bit and survives as well
    if (SOFT_RESET) begin
      next_s.wake_out_en = RST_CTRL[CTRL_WAKE_OUT_EN];
      next_s.irq_level_select = RST_CTRL[CTRL_LEVEL_SEL];
      next_s.wake_state_route_second = RST_CTRL[CTRL_WAKE_ROUTE2];
      next_s.irq_en = RST_EV;
      next_s.irq_stat = RST_EV;
    end
    // deep power-off clears the disable bit
    if (DEEP_POWER_OFF) begin
      next_s.boot_event_disable = RST_CTRL[CTRL_BOOT_EVENT_DISABLE];
      next_s.boot_route_second = RST_CTRL[CTRL_BOOT_ROUTE2];
    end
    // new events set sticky bits, winning over a clear
    // irq is taken from the next stored bits, so it rises with the event
    next_s.irq_stat = next_s.irq_stat | ev;
    next_s.irq = |(next_s.irq_stat & next_s.irq_en);
    // boot pulse routed by its routing bit
    act1 = short_busy && !s.boot_route_second;
    act2 = short_busy && s.boot_route_second;
    // wake routed by its routing bit
    // a boot pulse and a wake indication on one pin are merged
    if (wake_on) begin
      if (s.wake_state_route_second) begin
        act2 = 1'b1;
      end else begin
        act1 = 1'b1;
      end
    end
    // strap high: second pin carries only the boot event
    if (s.boot_strap_select) begin
      act2 = 1'b0;
    end
    // asserted pins take the selected level, idle the opposite
    next_s.pin1 = act1 ? s.irq_level_select : !s.irq_level_select;
    next_s.pin2 = act2 ? s.irq_level_select : !s.irq_level_select;
    // long boot pulse is always low
    if (long_busy) begin
      next_s.pin2 = 1'b0;
    end
  end

  // state register; supply loss clears everything except the two pins, which reset high
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      s <= '0;
      s.pin1 <= 1'b1;
      s.pin2 <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flip-flops
  assign PRDATA = s.prdata;
  assign PREADY = s.pready;
  assign PSLVERR = s.pslverr;
  assign FIRST_IRQ_PIN = s.pin1;
  assign SECOND_IRQ_BOOT_PIN = s.pin2;
  assign IRQ = s.irq;

  // helper: length of the last short pulse
  // counted from zero at the launching edge, so it ends equal to the count
  bwio_cnt_t short_len;
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      short_len <= '0;
    end else if (short_start) begin
      short_len <= '0;
    end else if (short_busy) begin
      short_len <= short_len + bwio_cnt_t'(1);
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  // wake held, then left, with setup steady
  sequence wake_then_leave;
    (wake_on && !s.wake_state_route_second) ##1
      (!wake_now && s.wake_out_en && !s.wake_state_route_second &&
       !short_busy && !s.boot_strap_select);
  endsequence

  // boot done taken: strap low and the event enabled
  sequence boot_done_taken;
    BOOT_DONE_EVENT && s.strap_taken && !s.boot_strap_select && !s.boot_event_disable;
  endsequence

  // boot start taken: strap high, disable bit ignored
  sequence boot_start_taken;
    BOOT_START && s.strap_taken && s.boot_strap_select;
  endsequence

  chk_dis_blocks_boot: assert property (
    s.boot_event_disable && !s.boot_strap_select && !short_busy && BOOT_DONE_EVENT
      |=> !short_busy)
    else $error("boot pulse launched while disabled");
  chk_short_pulse_len: assert property (
    $fell(short_busy) |-> short_len == SHORT_CYC)
    else $error("short boot pulse has wrong length");
  chk_long_pulse_low: assert property (
    long_busy |=> !SECOND_IRQ_BOOT_PIN)
    else $error("second pin not low during long boot pulse");
  chk_soft_keeps_dis: assert property (
    SOFT_RESET && !wr_commit && !DEEP_POWER_OFF |=> $stable(s.boot_event_disable))
    else $error("soft reset altered boot disable");
  chk_wake_off_idle: assert property (
    !s.wake_out_en && !short_busy |=> FIRST_IRQ_PIN == !$past(s.irq_level_select))
    else $error("first pin not idle with wake output off");
  chk_wake_level_held: assert property (
    wake_on && !s.wake_state_route_second |=> FIRST_IRQ_PIN == $past(s.irq_level_select))
    else $error("wake not shown at active level");
  chk_wake_exit_level: assert property (
    wake_then_leave |=> FIRST_IRQ_PIN == !$past(s.irq_level_select))
    else $error("pin not inactive after leaving wake");
  chk_wake_route_sec: assert property (
    wake_on && s.wake_state_route_second && !s.boot_strap_select && !long_busy
      |=> SECOND_IRQ_BOOT_PIN == $past(s.irq_level_select))
    else $error("wake not routed to second pin");
  chk_apb_answer: assert property (
    apb_access |=> PREADY ##1 !PREADY)
    else $error("apb answer not one cycle long");
  chk_err_unmapped: assert property (
    apb_access && !reg_hit(PADDR) |=> PSLVERR && (PRDATA == '0))
    else $error("unmapped access not refused");
  chk_short_starts: assert property (
    boot_done_taken |=> short_busy)
    else $error("short boot pulse not started");
  chk_long_starts: assert property (
    boot_start_taken |=> long_busy)
    else $error("long boot pulse not started");
  chk_boot_first_pin: assert property (
    short_busy && !s.boot_route_second |=> FIRST_IRQ_PIN == $past(s.irq_level_select))
    else $error("boot pulse not shown on first pin");
  chk_boot_second_pin: assert property (
    short_busy && s.boot_route_second && !s.boot_strap_select
      |=> SECOND_IRQ_BOOT_PIN == $past(s.irq_level_select))
    else $error("boot pulse not shown on second pin");
  chk_strap_pin_idle: assert property (
    s.boot_strap_select && !long_busy |=> SECOND_IRQ_BOOT_PIN == !$past(s.irq_level_select))
    else $error("second pin not idle with strap high");
  chk_soft_keeps_route: assert property (
    SOFT_RESET && !wr_commit && !DEEP_POWER_OFF |=> $stable(s.boot_route_second))
    else $error("soft reset altered boot routing");
  chk_wake_irq_set: assert property (
    wake_now && !s.wake_prev |=> s.irq_stat[EV_WAKE_IN])
    else $error("wake entry not recorded");
  chk_wake_exit_set: assert property (
    !wake_now && s.wake_prev |=> s.irq_stat[EV_WAKE_OUT])
    else $error("wake exit not recorded");
endmodule : bwio_irq_out

// ### test/bwio_load_switch.sv
// load switch model: follows one interrupt pin and measures active runs
`timescale 1ns/1ps
module bwio_load_switch (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic pin,
  input wire logic active_high,
  output logic load_on,
  output int last_len
);
  int run; // cycles the pin has been active so far

  // the switch closes while the pin sits at its active level
  assign load_on = (pin === active_high);

  // count each active run and keep its length once the pin falls back
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      run <= 0;
      last_len <= 0;
    end else if (load_on) begin
      run <= run + 1;
    end else if (run != 0) begin
      last_len <= run;
      run <= 0;
    end
  end
endmodule : bwio_load_switch

// ### test/testbench.sv
// testbench: apb-driven checks of boot pulses and wake output pins
`timescale 1ns/1ps
module testbench;
  import bwio_pkg::*;
  localparam int SHORT_CYC = 50; // 1 us at 20 ns
  localparam int LONG_CYC = 1; // long time set to zero, clamped to one cycle
  localparam int E_START = 0;
  localparam int E_DONE = 1;
  localparam int E_SRST = 2;
  localparam int E_DPO = 3;
  logic clk = 1'b0;
  logic rst_b, psel, penable, pwrite, pready, pslverr, strap, pin1, pin2, irq, lvl, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [1:0] pwr;
  logic [3:0] evs; // boot start, boot done, soft reset, deep power-off
  int len1, len2, mismatches, comparisons, hits;

  always #10 clk = ~clk;

  bwio_irq_out #(.BOOT_SHORT_US(1), .BOOT_LONG_MS(0)) DUT (.CLK_SYS(clk), .RST_B(rst_b),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .POWER_STATE(pwr),
    .BOOT_STRAP_SELECT(strap), .BOOT_START(evs[E_START]), .BOOT_DONE_EVENT(evs[E_DONE]),
    .SOFT_RESET(evs[E_SRST]), .DEEP_POWER_OFF(evs[E_DPO]), .FIRST_IRQ_PIN(pin1),
    .SECOND_IRQ_BOOT_PIN(pin2), .IRQ(irq));
  bwio_load_switch sw1 (.CLK_SYS(clk), .RST_B(rst_b), .pin(pin1), .active_high(lvl),
    .load_on(), .last_len(len1));
  bwio_load_switch sw2 (.CLK_SYS(clk), .RST_B(rst_b), .pin(pin2), .active_high(lvl),
    .load_on(), .last_len(len2));

  // print counts and verdict, then stop
  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // compare one value against its expectation
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // wait for ready however long it takes; only the watchdog ends a hang
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd

  // one-cycle event pulse
  task ev(input int k);
    evs[k] <= 1'b1;
    @(posedge clk);
    evs <= 4'h0;
    @(posedge clk);
  endtask : ev

  // let the pins settle, then compare both
  task pins(input logic a, input logic b);
    repeat (3) @(posedge clk);
    chk({30'h0, pin1, pin2}, {30'h0, a, b});
  endtask : pins

  // main sequence
  initial begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; pwr = 2'h0; strap = 1'b0; evs = 4'h0; lvl = 1'b0; hits = 0;
    repeat (16) @(posedge clk);
    chk({30'h0, pin1, pin2}, 32'h3);
    chk({31'h0, irq}, 32'h0);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    rd(OFF_CTRL, 32'h0);
    rd(OFF_IRQ_EN, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    // short boot pulse, active low on the first pin, raising the interrupt
    wr(OFF_IRQ_EN, 32'h1);
    ev(E_DONE);
    repeat (SHORT_CYC + 5) @(posedge clk);
    chk(len1, SHORT_CYC);
    chk({31'h0, irq}, 32'h1);
    rd(OFF_IRQ_STAT, 32'h1);
    wr(OFF_IRQ_CLR, 32'h1);
    rd(OFF_IRQ_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // active-high pulse routed to the second pin
    wr(OFF_CTRL, 32'h14);
    lvl <= 1'b1;
    ev(E_DONE);
    repeat (SHORT_CYC + 5) @(posedge clk);
    chk(len2, SHORT_CYC);
    // disabled boot event leaves both pins idle
    wr(OFF_CTRL, 32'h16);
    ev(E_DONE);
    for (int i = 0; i < SHORT_CYC + 10; i++) begin
      @(posedge clk);
      if (pin1 !== 1'b0 || pin2 !== 1'b0) hits++;
    end
    chk(hits, 0);
    // soft reset keeps disable and boot route, power-off clears them
    wr(OFF_CTRL, 32'h17);
    ev(E_SRST);
    lvl <= 1'b0; // soft reset returns the pins to active low
    rd(OFF_CTRL, 32'h12);
    ev(E_DPO);
    rd(OFF_CTRL, 32'h0);
    // wake on the first pin, active low, with only the wake entry interrupt enabled
    wr(OFF_IRQ_EN, 32'h2);
    wr(OFF_CTRL, 32'h01);
    pwr <= PWR_WAKE;
    pins(1'b0, 1'b1);
    chk({31'h0, irq}, 32'h1);
    rd(OFF_STATUS, 32'h41);
    pwr <= 2'h2;
    pins(1'b1, 1'b1);
    rd(OFF_IRQ_STAT, 32'h6);
    wr(OFF_IRQ_EN, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_IRQ_CLR, 32'h7);
    // wake on the second pin, active high, then with wake output off
    wr(OFF_CTRL, 32'h0D);
    lvl <= 1'b1;
    pwr <= PWR_WAKE;
    pins(1'b0, 1'b1);
    pwr <= 2'h3;
    pins(1'b0, 1'b0);
    chk(len2, 3);
    wr(OFF_CTRL, 32'h0C);
    pwr <= PWR_WAKE;
    pins(1'b0, 1'b0);
    // strap high: second pin low for the long count, disable ignored
    pwr <= 2'h0;
    rst_b <= 1'b0;
    strap <= 1'b1;
    lvl <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    wr(OFF_CTRL, 32'h02);
    ev(E_START);
    repeat (10) @(posedge clk);
    chk(len2, LONG_CYC);
    summarize;
  end

  // watchdog against a hung handshake
  initial begin
    #(20 * 20000);
    mismatches++;
    summarize;
  end
endmodule : testbench
